// ### duec_ctrl.v
// dynamic update event controller for one converter tile, with per-block
// staged/active settings, quadrature correction datapath and pll divider limits.
// assumes fabric strobes and marker arrive synchronous to CORE_CLK_IN, which
// stands for the tile converter output clock.
`timescale 1ns/1ps
`include "duec_consts.vh"
module duec_ctrl #(
    parameter NBLK = 4,
    parameter IS_TX = 1,
    parameter IS_RX4G = 0,
    parameter PLL_BUILT = 1,
    parameter MIX_W = 32,
    parameter DLY_W = 4
) (
    // clock and reset
    input wire CORE_CLK_IN,
    input wire RST_IN,
    // configuration write port
    input wire CFG_WR_IN,
    input wire [1:0] CFG_BLK_IN,
    input wire [1:0] CFG_FEAT_IN,
    input wire [2:0] CFG_TRIG_IN,
    input wire [MIX_W-1:0] CFG_MIX_IN,
    input wire [15:0] CFG_GAIN_I_IN,
    input wire [15:0] CFG_GAIN_Q_IN,
    input wire [15:0] CFG_PHASE_IN,
    input wire [15:0] CFG_OFFSET_IN,
    input wire [DLY_W-1:0] CFG_DLY_IN,
    // event sources
    input wire BLK_EVENT_WR_IN,
    input wire [1:0] BLK_EVENT_SEL_IN,
    input wire TILE_EVENT_WR_IN,
    input wire FABRIC_UPDATE_STROBE_IN,
    input wire SYSREF_IN,
    input wire MARKER_IN,
    // correction datapath, one pair i/q per pair of blocks
    input wire [16*NBLK-1:0] SAMPLE_IN,
    output reg [16*NBLK-1:0] SAMPLE_OUT,
    input wire [NBLK-1:0] OVF_EN_IN,
    input wire [NBLK-1:0] OVF_CLR_IN,
    output reg [NBLK-1:0] CORR_GAIN_PHASE_OVF_FLAG_OUT,
    output reg [NBLK-1:0] CORR_OFFSET_OVF_FLAG_OUT,
    output wire [NBLK-1:0] CORR_OVF_IRQ_OUT,
    // active settings readback
    input wire [1:0] RD_BLK_IN,
    output reg [15:0] RD_GAIN_OUT,
    output reg [15:0] RD_PHASE_OUT,
    output reg [15:0] RD_OFFSET_OUT,
    output reg [MIX_W-1:0] RD_MIX_OUT,
    output reg [DLY_W-1:0] RD_DLY_OUT,
    output reg [NBLK-1:0] PENDING_OUT,
    output reg CFG_REJECT_OUT,
    // pll control
    input wire PLL_WR_IN,
    input wire [7:0] PLL_REF_IN,
    input wire [7:0] PLL_FB_IN,
    input wire [7:0] PLL_OUT_IN,
    input wire CLK_SEL_PLL_IN,
    output reg [7:0] PLL_REF_OUT,
    output reg [7:0] PLL_FB_OUT,
    output reg [7:0] PLL_OUT_OUT,
    output reg PLL_REJECT_OUT,
    output reg CLK_SEL_PLL_OUT
);

    // clip to [lo,hi], signed
    function [15:0] sclip;
        input signed [17:0] v;
        begin
            if (v > 18'sh07FFF)
                sclip = `DUEC_SAT_MAX;
            else if (v < -18'sh08000)
                sclip = `DUEC_SAT_MIN;
            else
                sclip = v[15:0];
        end
    endfunction

    // trigger code legal for this tile
    function legal_trig;
        input [2:0] t;
        begin
            case (t)
                `DUEC_TRIG_IMMEDIATE, `DUEC_TRIG_BLOCK: legal_trig = (IS_RX4G == 0);
                `DUEC_TRIG_TILE, `DUEC_TRIG_FABRIC, `DUEC_TRIG_SYSREF: legal_trig = 1'b1;
                `DUEC_TRIG_MARKER: legal_trig = (IS_TX != 0);
                default: legal_trig = 1'b0;
            endcase
        end
    endfunction

    // staged and active settings, per block
    reg [MIX_W-1:0] mix_stg_q [0:NBLK-1];
    reg [MIX_W-1:0] mix_act_q [0:NBLK-1];
    reg [15:0] gain_stg_q [0:NBLK-1];
    reg [15:0] gain_act_q [0:NBLK-1];
    reg [15:0] ph_stg_q [0:NBLK-1];
    reg [15:0] ph_act_q [0:NBLK-1];
    reg [15:0] off_stg_q [0:NBLK-1];
    reg [15:0] off_act_q [0:NBLK-1];
    reg [DLY_W-1:0] dly_stg_q [0:NBLK-1];
    reg [DLY_W-1:0] dly_act_q [0:NBLK-1];
    reg [2:0] trig_q [0:NBLK*3-1];
    reg [NBLK*3-1:0] pend_q;
    reg sysref_q;
    reg [NBLK*3-1:0] fire;
    integer b;
    integer f;
    integer k;
    integer m;
    integer r;

    // sysref edge detect; input already synchronous
    wire sysref_rise = SYSREF_IN & ~sysref_q;
    wire cfg_ok = CFG_WR_IN && legal_trig(CFG_TRIG_IN) && (CFG_FEAT_IN <= 2'h2)
        && ({1'b0, CFG_BLK_IN} < NBLK);

    // which pending features release this cycle
    always @* begin
        fire = {NBLK*3{1'b0}};
        for (k = 0; k < NBLK*3; k = k + 1) begin
            case (trig_q[k])
                `DUEC_TRIG_IMMEDIATE: fire[k] = 1'b1;
                `DUEC_TRIG_BLOCK: fire[k] = BLK_EVENT_WR_IN && (BLK_EVENT_SEL_IN == k/3);
                // any block event request acts as a tile event here
                `DUEC_TRIG_TILE: fire[k] = TILE_EVENT_WR_IN | BLK_EVENT_WR_IN;
                `DUEC_TRIG_FABRIC: fire[k] = FABRIC_UPDATE_STROBE_IN;
                `DUEC_TRIG_SYSREF: fire[k] = sysref_rise;
                `DUEC_TRIG_MARKER: fire[k] = MARKER_IN;
                default: fire[k] = 1'b0;
            endcase
            fire[k] = fire[k] & pend_q[k];
        end
    end

    // staging and single-edge transfer to active
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sysref_q <= 1'b0;
            pend_q <= {NBLK*3{1'b0}};
            CFG_REJECT_OUT <= 1'b0;
            for (b = 0; b < NBLK; b = b + 1) begin
                mix_stg_q[b] <= {MIX_W{1'b0}};
                mix_act_q[b] <= {MIX_W{1'b0}};
                gain_stg_q[b] <= `DUEC_GAIN_UNITY;
                gain_act_q[b] <= `DUEC_GAIN_UNITY;
                ph_stg_q[b] <= 16'h0000;
                ph_act_q[b] <= 16'h0000;
                off_stg_q[b] <= 16'h0000;
                off_act_q[b] <= 16'h0000;
                dly_stg_q[b] <= {DLY_W{1'b0}};
                dly_act_q[b] <= {DLY_W{1'b0}};
            end
            for (f = 0; f < NBLK*3; f = f + 1)
                trig_q[f] <= `DUEC_TRIG_TILE;
        end else begin
            sysref_q <= SYSREF_IN;
            CFG_REJECT_OUT <= CFG_WR_IN & ~cfg_ok;
            // release first so a write in the same cycle stays pending
            for (b = 0; b < NBLK; b = b + 1) begin
                if (fire[b*3+`DUEC_FEAT_MIXER])
                    mix_act_q[b] <= mix_stg_q[b];
                if (fire[b*3+`DUEC_FEAT_CORR]) begin
                    gain_act_q[b] <= gain_stg_q[b];
                    ph_act_q[b] <= ph_stg_q[b];
                    off_act_q[b] <= off_stg_q[b];
                end
                if (fire[b*3+`DUEC_FEAT_DELAY])
                    dly_act_q[b] <= dly_stg_q[b];
            end
            pend_q <= pend_q & ~fire;
            if (cfg_ok) begin
                trig_q[CFG_BLK_IN*3+CFG_FEAT_IN] <= CFG_TRIG_IN;
                pend_q[CFG_BLK_IN*3+CFG_FEAT_IN] <= 1'b1;
                case (CFG_FEAT_IN)
                    2'h0: mix_stg_q[CFG_BLK_IN] <= CFG_MIX_IN;
                    2'h1: begin
                        // odd block takes the q gain, even the i gain
                        gain_stg_q[CFG_BLK_IN] <= (CFG_BLK_IN[0] ? CFG_GAIN_Q_IN
                            : CFG_GAIN_I_IN) > `DUEC_GAIN_MAX ? `DUEC_GAIN_MAX
                            : (CFG_BLK_IN[0] ? CFG_GAIN_Q_IN : CFG_GAIN_I_IN);
                        if ($signed(CFG_PHASE_IN) > $signed(`DUEC_PHASE_MAX))
                            ph_stg_q[CFG_BLK_IN] <= `DUEC_PHASE_MAX;
                        else if ($signed(CFG_PHASE_IN) < $signed(`DUEC_PHASE_MIN))
                            ph_stg_q[CFG_BLK_IN] <= `DUEC_PHASE_MIN;
                        else
                            ph_stg_q[CFG_BLK_IN] <= CFG_PHASE_IN;
                        off_stg_q[CFG_BLK_IN] <= CFG_OFFSET_IN;
                    end
                    default: dly_stg_q[CFG_BLK_IN] <= CFG_DLY_IN;
                endcase
            end
        end
    end

    // correction datapath: i on even block, q on the odd partner
    reg signed [15:0] xs;
    reg signed [15:0] qs;
    reg signed [32:0] gp;
    reg signed [32:0] pp;
    reg signed [17:0] gv;
    reg signed [17:0] ov;
    reg [NBLK-1:0] gp_ovf;
    reg [NBLK-1:0] of_ovf;
    reg [16*NBLK-1:0] samp_d;
    always @* begin
        gp_ovf = {NBLK{1'b0}};
        of_ovf = {NBLK{1'b0}};
        samp_d = {16*NBLK{1'b0}};
        xs = 16'sh0000;
        qs = 16'sh0000;
        gp = 33'sh0;
        pp = 33'sh0;
        gv = 18'sh0;
        ov = 18'sh0;
        for (m = 0; m < NBLK; m = m + 1) begin
            xs = SAMPLE_IN[16*m +: 16];
            qs = SAMPLE_IN[16*(m|1) +: 16];
            // phase: add scaled q onto i path only
            pp = (m % 2 == 0) ? ($signed(ph_act_q[m]) * qs) : 33'sh0;
            gp = ((($signed({{17{xs[15]}}, xs}) <<< 15) + pp) >>> 15)
                * $signed({1'b0, gain_act_q[m]});
            gp = gp >>> 14;
            gv = (gp > 33'sh07FFF) ? 18'sh07FFF : (gp < -33'sh08000) ? -18'sh08000
                : gp[17:0];
            gp_ovf[m] = (gp > 33'sh07FFF) || (gp < -33'sh08000);
            ov = gv + $signed({{2{off_act_q[m][15]}}, off_act_q[m]});
            of_ovf[m] = (ov > 18'sh07FFF) || (ov < -18'sh08000);
            samp_d[16*m +: 16] = sclip(ov);
        end
    end

    // registered datapath outputs and sticky flags; set wins over clear
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SAMPLE_OUT <= {16*NBLK{1'b0}};
            CORR_GAIN_PHASE_OVF_FLAG_OUT <= {NBLK{1'b0}};
            CORR_OFFSET_OVF_FLAG_OUT <= {NBLK{1'b0}};
        end else begin
            SAMPLE_OUT <= samp_d;
            CORR_GAIN_PHASE_OVF_FLAG_OUT <= (CORR_GAIN_PHASE_OVF_FLAG_OUT & ~OVF_CLR_IN)
                | gp_ovf;
            CORR_OFFSET_OVF_FLAG_OUT <= (CORR_OFFSET_OVF_FLAG_OUT & ~OVF_CLR_IN) | of_ovf;
        end
    end
    assign CORR_OVF_IRQ_OUT = (CORR_GAIN_PHASE_OVF_FLAG_OUT | CORR_OFFSET_OVF_FLAG_OUT)
        & OVF_EN_IN;

    // readback of applied settings
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RD_GAIN_OUT <= 16'h0000;
            RD_PHASE_OUT <= 16'h0000;
            RD_OFFSET_OUT <= 16'h0000;
            RD_MIX_OUT <= {MIX_W{1'b0}};
            RD_DLY_OUT <= {DLY_W{1'b0}};
            PENDING_OUT <= {NBLK{1'b0}};
        end else begin
            RD_GAIN_OUT <= gain_act_q[RD_BLK_IN];
            RD_PHASE_OUT <= ph_act_q[RD_BLK_IN];
            RD_OFFSET_OUT <= off_act_q[RD_BLK_IN];
            RD_MIX_OUT <= mix_act_q[RD_BLK_IN];
            RD_DLY_OUT <= dly_act_q[RD_BLK_IN];
            for (r = 0; r < NBLK; r = r + 1)
                PENDING_OUT[r] <= |pend_q[r*3 +: 3];
        end
    end

    // pll dividers: out-of-range or no-pll writes are refused whole
    wire pll_ok = (PLL_BUILT != 0)
        && PLL_REF_IN >= `DUEC_PLL_REF_MIN && PLL_REF_IN <= `DUEC_PLL_REF_MAX
        && PLL_FB_IN >= `DUEC_PLL_FB_MIN && PLL_FB_IN <= `DUEC_PLL_FB_MAX
        && PLL_OUT_IN >= `DUEC_PLL_OUT_MIN && PLL_OUT_IN <= `DUEC_PLL_OUT_MAX;
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PLL_REF_OUT <= `DUEC_PLL_REF_RST;
            PLL_FB_OUT <= `DUEC_PLL_FB_RST;
            PLL_OUT_OUT <= `DUEC_PLL_OUT_RST;
            PLL_REJECT_OUT <= 1'b0;
            CLK_SEL_PLL_OUT <= 1'b0;
        end else begin
            PLL_REJECT_OUT <= PLL_WR_IN & ~pll_ok;
            if (PLL_WR_IN && pll_ok) begin
                PLL_REF_OUT <= PLL_REF_IN;
                PLL_FB_OUT <= PLL_FB_IN;
                PLL_OUT_OUT <= PLL_OUT_IN;
            end
            // direct clock forced when no pll exists
            CLK_SEL_PLL_OUT <= CLK_SEL_PLL_IN && (PLL_BUILT != 0);
        end
    end
endmodule

// ### duec_consts.vh
// constants for the dynamic update event controller
// assumes inclusion by the single design module, no other users
`ifndef DUEC_CONSTS_VH
`define DUEC_CONSTS_VH
// trigger select codes, 3 bits
`define DUEC_TRIG_IMMEDIATE 3'h0
`define DUEC_TRIG_BLOCK 3'h1
`define DUEC_TRIG_TILE 3'h2
`define DUEC_TRIG_FABRIC 3'h3
`define DUEC_TRIG_SYSREF 3'h4
`define DUEC_TRIG_MARKER 3'h5
// feature indices
`define DUEC_FEAT_MIXER 0
`define DUEC_FEAT_CORR 1
`define DUEC_FEAT_DELAY 2
// gain factor: unsigned 2.14, 2.0 = 0x8000
`define DUEC_GAIN_MAX 16'h8000
`define DUEC_GAIN_UNITY 16'h4000
// phase factor: signed 1.15 clipped to +/-0.5
`define DUEC_PHASE_MAX 16'h4000
`define DUEC_PHASE_MIN 16'hC000
// sample saturation limits
`define DUEC_SAT_MAX 16'h7FFF
`define DUEC_SAT_MIN 16'h8000
// pll divider limits
`define DUEC_PLL_REF_MIN 8'h01
`define DUEC_PLL_REF_MAX 8'h04
`define DUEC_PLL_FB_MIN 8'h0D
`define DUEC_PLL_FB_MAX 8'hA0
`define DUEC_PLL_OUT_MIN 8'h02
`define DUEC_PLL_OUT_MAX 8'h40
// reset values
`define DUEC_PLL_REF_RST 8'h01
`define DUEC_PLL_FB_RST 8'h0D
`define DUEC_PLL_OUT_RST 8'h02
`endif

// ### duec_ctrl_properties.sv
// checker for the update event controller, port level only
// assumes it is bound onto duec_ctrl with the same NBLK
`timescale 1ns/1ps
module duec_ctrl_properties #(parameter NBLK = 4) (
    // control and events, grouped to keep the checker short
    input wire CORE_CLK_IN, RST_IN, CFG_WR_IN, BLK_EVENT_WR_IN, TILE_EVENT_WR_IN,
    input wire FABRIC_UPDATE_STROBE_IN, SYSREF_IN, MARKER_IN, PLL_WR_IN,
    input wire [1:0] CFG_BLK_IN, CFG_FEAT_IN, RD_BLK_IN,
    input wire [2:0] CFG_TRIG_IN,
    // observed results
    input wire CFG_REJECT_OUT, PLL_REJECT_OUT,
    input wire [15:0] RD_GAIN_OUT, RD_OFFSET_OUT,
    input wire [NBLK-1:0] PENDING_OUT, OVF_EN_IN, OVF_CLR_IN, CORR_OVF_IRQ_OUT,
    input wire [NBLK-1:0] CORR_GAIN_PHASE_OVF_FLAG_OUT, CORR_OFFSET_OVF_FLAG_OUT,
    input wire [7:0] PLL_REF_IN, PLL_FB_IN, PLL_OUT_IN, PLL_REF_OUT, PLL_FB_OUT, PLL_OUT_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    // no config write and no event of any kind this cycle
    wire quiet = !(CFG_WR_IN | BLK_EVENT_WR_IN | TILE_EVENT_WR_IN | FABRIC_UPDATE_STROBE_IN
        | SYSREF_IN | MARKER_IN);
    wire cfg_bad = CFG_TRIG_IN > 3'h5 || CFG_FEAT_IN == 2'h3;
    wire pll_bad = PLL_REF_IN < 8'h01 || PLL_REF_IN > 8'h04 || PLL_FB_IN < 8'h0D
        || PLL_FB_IN > 8'hA0 || PLL_OUT_IN < 8'h02 || PLL_OUT_IN > 8'h40;
    // four quiet cycles cover the write, release and readback latencies
    sequence quiet_s;
        (quiet && $stable(RD_BLK_IN)) [*4];
    endsequence
    sequence tile_stage_s;
        (!PENDING_OUT[0] && !CFG_WR_IN) [*2] ##1
        (CFG_WR_IN && !cfg_bad && CFG_TRIG_IN == 3'h2 && CFG_BLK_IN == 2'h0) ##1
        (!CFG_WR_IN) [*3] ##1 (!CFG_WR_IN && (TILE_EVENT_WR_IN || BLK_EVENT_WR_IN));
    endsequence
    hold_until_trigger_a: assert property (
        quiet_s |=> $stable(RD_GAIN_OUT) && $stable(RD_OFFSET_OUT)) else $error("active moved");
    stage_sets_pending_a: assert property (
        CFG_WR_IN && !cfg_bad && CFG_TRIG_IN != 3'h0 && CFG_BLK_IN == 2'h0
        |-> ##[1:2] PENDING_OUT[0]) else $error("write not pending");
    tile_release_a: assert property (
        tile_stage_s |-> ##2 (!PENDING_OUT[0] || $past(CFG_WR_IN))) else $error("not released");
    bad_code_refused_a: assert property (
        CFG_WR_IN && cfg_bad |=> CFG_REJECT_OUT) else $error("bad write taken");
    good_code_taken_a: assert property (
        CFG_WR_IN && !cfg_bad |=> !CFG_REJECT_OUT) else $error("good write refused");
    irq_enable_gate_a: assert property (
        CORR_OVF_IRQ_OUT == ((CORR_GAIN_PHASE_OVF_FLAG_OUT | CORR_OFFSET_OVF_FLAG_OUT)
        & OVF_EN_IN)) else $error("irq gate wrong");
    flag_sticky_a: assert property (
        1'h1 |=> (($past(CORR_GAIN_PHASE_OVF_FLAG_OUT) & ~$past(OVF_CLR_IN))
        & ~CORR_GAIN_PHASE_OVF_FLAG_OUT) == {NBLK{1'h0}}) else $error("flag lost");
    pll_range_refused_a: assert property (
        PLL_WR_IN && pll_bad |=> PLL_REJECT_OUT && $stable(PLL_FB_OUT) && $stable(PLL_REF_OUT)
        && $stable(PLL_OUT_OUT)) else $error("bad divider taken");
    pll_value_taken_a: assert property (
        PLL_WR_IN && !pll_bad |=> !PLL_REJECT_OUT && PLL_REF_OUT == $past(PLL_REF_IN)
        && PLL_FB_OUT == $past(PLL_FB_IN) && PLL_OUT_OUT == $past(PLL_OUT_IN))
        else $error("divider not taken");
endmodule
bind duec_ctrl duec_ctrl_properties #(.NBLK(NBLK)) props (.*);

// ### duec_fabric_model.sv
// fabric-side model: update strobe, sysref and marker pulses
// assumes the bench requests a pulse one cycle ahead; lines idle low
`timescale 1ns/1ps
module duec_fabric_model (
    // tile output clock and request
    input wire clk_in,
    input wire go_in,
    input wire [1:0] kind_in,
    // strobes towards the tile
    output reg strobe_out,
    output reg sysref_out,
    output reg marker_out
);
    initial {strobe_out, sysref_out, marker_out} = 3'h0;
    // launched just after the edge, so the tile samples them cleanly
    always @(posedge clk_in) begin
        strobe_out <= #1 go_in && kind_in == 2'h1;
        sysref_out <= #1 go_in && kind_in == 2'h2;
        marker_out <= #1 go_in && kind_in == 2'h3;
    end
endmodule

// ### duec_ctrl_bench.sv
// self-checking bench for the update event controller
// assumes the fabric model answers a request on the next edge
`timescale 1ns/1ps
module duec_ctrl_bench;
    reg CORE_CLK_IN = 1'h0, RST_IN = 1'h1, CFG_WR_IN = 1'h0, BLK_EVENT_WR_IN = 1'h0;
    reg TILE_EVENT_WR_IN = 1'h0, PLL_WR_IN = 1'h0, CLK_SEL_PLL_IN = 1'h0, go = 1'h0;
    reg [1:0] CFG_BLK_IN = 2'h0, CFG_FEAT_IN = 2'h1, BLK_EVENT_SEL_IN = 2'h2, RD_BLK_IN = 2'h0;
    reg [1:0] kind = 2'h0;
    reg [2:0] CFG_TRIG_IN = 3'h0;
    reg [31:0] CFG_MIX_IN = 32'h0;
    reg [15:0] CFG_GAIN_I_IN = 16'h0, CFG_GAIN_Q_IN = 16'h0, CFG_PHASE_IN = 16'h0;
    reg [15:0] CFG_OFFSET_IN = 16'h0;
    reg [3:0] CFG_DLY_IN = 4'h0, OVF_EN_IN = 4'h0, OVF_CLR_IN = 4'h0;
    reg [63:0] SAMPLE_IN = 64'h0;
    reg [7:0] PLL_REF_IN = 8'h0, PLL_FB_IN = 8'h0, PLL_OUT_IN = 8'h0;
    reg [23:0] pll_exp = 24'h010D02;
    wire FABRIC_UPDATE_STROBE_IN, SYSREF_IN, MARKER_IN, CFG_REJECT_OUT, PLL_REJECT_OUT;
    wire CLK_SEL_PLL_OUT;
    wire [63:0] SAMPLE_OUT;
    wire [3:0] CORR_GAIN_PHASE_OVF_FLAG_OUT, CORR_OFFSET_OVF_FLAG_OUT, CORR_OVF_IRQ_OUT;
    wire [3:0] PENDING_OUT, RD_DLY_OUT;
    wire [15:0] RD_GAIN_OUT, RD_PHASE_OUT, RD_OFFSET_OUT;
    wire [31:0] RD_MIX_OUT;
    wire [7:0] PLL_REF_OUT, PLL_FB_OUT, PLL_OUT_OUT;
    integer err_count = 0, comparisons = 0, t;
    duec_ctrl uut (.*);
    duec_fabric_model far_end (.clk_in(CORE_CLK_IN), .go_in(go), .kind_in(kind),
        .strobe_out(FABRIC_UPDATE_STROBE_IN), .sysref_out(SYSREF_IN), .marker_out(MARKER_IN));
    initial forever #2.5 CORE_CLK_IN = ~CORE_CLK_IN;
    // every drive lands 1 ns after the edge
    task tick(input integer n);
        repeat (n) begin
            @(posedge CORE_CLK_IN);
            #1;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // odd block takes the q gain, kept distinct by bit 8
    task cfg(input [1:0] b, input [2:0] tr, input [15:0] g, input [15:0] p, input [15:0] o);
        begin
            {CFG_BLK_IN, CFG_TRIG_IN, CFG_PHASE_IN, CFG_OFFSET_IN} = {b, tr, p, o};
            {CFG_GAIN_I_IN, CFG_GAIN_Q_IN} = {g, g | 16'h0100};
            CFG_WR_IN = 1'h1;
            tick(1);
            CFG_WR_IN = 1'h0;
        end
    endtask
    task rd(input [1:0] b, input [15:0] g);
        begin
            RD_BLK_IN = b;
            tick(3);
            chk(RD_GAIN_OUT, g);
        end
    endtask
    task fire(input [2:0] tr);
        begin
            case (tr)
                3'h1: BLK_EVENT_WR_IN = 1'h1;
                3'h2: TILE_EVENT_WR_IN = 1'h1;
                3'h3, 3'h4, 3'h5: {kind, go} = {tr[1:0] - 2'h2, 1'h1};
                default: ;
            endcase
            tick(1);
            {BLK_EVENT_WR_IN, TILE_EVENT_WR_IN, go} = 3'h0;
            tick(1);
        end
    endtask
    task pll(input [23:0] v, input rej);
        begin
            {PLL_REF_IN, PLL_FB_IN, PLL_OUT_IN} = v;
            PLL_WR_IN = 1'h1;
            tick(1);
            PLL_WR_IN = 1'h0;
            if (!rej) pll_exp = v;
            chk(PLL_REJECT_OUT, rej);
            chk({PLL_REF_OUT, PLL_FB_OUT, PLL_OUT_OUT}, pll_exp);
            tick(1);
        end
    endtask
    task t_reset;
        begin
            chk({PLL_REF_OUT, PLL_FB_OUT, PLL_OUT_OUT}, 24'h010D02);
            rd(2'h0, 16'h4000);
            CLK_SEL_PLL_IN = 1'h1;
            tick(2);
            chk(CLK_SEL_PLL_OUT, 1'h1);
        end
    endtask
    task t_pll;
        begin
            pll(24'h04A040, 1'h0);
            pll(24'h000D02, 1'h1);
            pll(24'h01A102, 1'h1);
            pll(24'h010D41, 1'h1);
            pll(24'h010D02, 1'h0);
        end
    endtask
    // tile trigger on blocks 0 and 1, released by one block event
    task t_pair;
        begin
            cfg(2'h1, 3'h2, 16'h3000, 16'h0, 16'h0);
            tick(2);
            cfg(2'h0, 3'h2, 16'h2000, 16'h0, 16'h0);
            rd(2'h1, 16'h4000);
            chk(PENDING_OUT[1:0], 2'h3);
            fire(3'h1);
            rd(2'h0, 16'h2000);
            rd(2'h1, 16'h3100);
            chk(PENDING_OUT, 4'h0);
        end
    endtask
    // every trigger kind on block 2: held first except immediate, applied after its event
    task t_kinds;
        begin
            for (t = 0; t < 6; t = t + 1) begin
                cfg(2'h2, t[2:0], 16'h1000 + t, 16'h0, 16'h0);
                if (t != 0) rd(2'h2, 16'h0FFF + t);
                fire(t[2:0]);
                rd(2'h2, 16'h1000 + t);
            end
        end
    endtask
    task t_corr;
        begin
            OVF_EN_IN = 4'h1;
            SAMPLE_IN = 64'h7000;
            cfg(2'h0, 3'h0, 16'hFFFF, 16'h7000, 16'h0);
            rd(2'h0, 16'h8000);
            chk(RD_PHASE_OUT, 16'h4000);
            tick(2);
            chk(SAMPLE_OUT[15:0], 16'h7FFF);
            chk(CORR_GAIN_PHASE_OVF_FLAG_OUT, 4'h1);
            chk(CORR_OVF_IRQ_OUT, 4'h1);
            SAMPLE_IN = 64'h1000;
            tick(2);
            OVF_CLR_IN = 4'hF;
            tick(1);
            OVF_CLR_IN = 4'h0;
            cfg(2'h0, 3'h0, 16'h4000, 16'h0, 16'h7FFF);
            tick(4);
            chk(SAMPLE_OUT[15:0], 16'h7FFF);
            chk(CORR_OFFSET_OVF_FLAG_OUT, 4'h1);
            chk(CORR_GAIN_PHASE_OVF_FLAG_OUT, 4'h0);
            // clear while the overflow persists: the set must win
            OVF_CLR_IN = 4'h1;
            OVF_EN_IN = 4'h2;
            tick(1);
            OVF_CLR_IN = 4'h0;
            chk(CORR_OFFSET_OVF_FLAG_OUT, 4'h1);
            chk(CORR_OVF_IRQ_OUT, 4'h0);
            // phase clipped to -0.5: i = 0x1800 - 0x1000/2, q keeps its own gain
            SAMPLE_IN = 64'h10001800;
            cfg(2'h0, 3'h0, 16'h4000, 16'hA000, 16'h0);
            rd(2'h0, 16'h4000);
            chk(RD_PHASE_OUT, 16'hC000);
            chk(RD_OFFSET_OUT, 16'h0000);
            chk(SAMPLE_OUT[15:0], 16'h1000);
            chk(SAMPLE_OUT[31:16], 16'h0C40);
        end
    endtask
    // mixer on block trigger and delay on sysref, both staged on block 3
    task t_feat;
        begin
            {CFG_FEAT_IN, CFG_MIX_IN, CFG_DLY_IN} = {2'h0, 32'h12345678, 4'hA};
            cfg(2'h3, 3'h1, 16'h1200, 16'h0, 16'h0);
            CFG_FEAT_IN = 2'h2;
            tick(1);
            cfg(2'h3, 3'h4, 16'h1200, 16'h0, 16'h0);
            fire(3'h1);
            rd(2'h3, 16'h4000);
            chk(RD_MIX_OUT, 32'h0);
            chk(RD_DLY_OUT, 4'h0);
            chk(PENDING_OUT, 4'h8);
            BLK_EVENT_SEL_IN = 2'h3;
            fire(3'h1);
            rd(2'h3, 16'h4000);
            chk(RD_MIX_OUT, 32'h12345678);
            chk(RD_DLY_OUT, 4'h0);
            fire(3'h4);
            rd(2'h3, 16'h4000);
            chk(RD_DLY_OUT, 4'hA);
            chk(RD_MIX_OUT, 32'h12345678);
            CFG_FEAT_IN = 2'h3;
            tick(1);
            cfg(2'h3, 3'h0, 16'h1200, 16'h0, 16'h0);
            chk(CFG_REJECT_OUT, 1'h1);
            CFG_FEAT_IN = 2'h1;
            tick(1);
        end
    endtask
    task t_refuse;
        begin
            cfg(2'h3, 3'h6, 16'h1200, 16'h0, 16'h0);
            chk(CFG_REJECT_OUT, 1'h1);
            rd(2'h3, 16'h4000);
        end
    endtask
    task tally_and_finish;
        begin
            if (err_count == 0 && comparisons > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    // a hang counts against the run
    initial begin
        #200000;
        err_count = err_count + 1;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge CORE_CLK_IN);
        #1 RST_IN = 1'h0;
        t_reset;
        t_pll;
        t_pair;
        t_kinds;
        t_corr;
        t_feat;
        t_refuse;
        tally_and_finish;
    end
endmodule
